/* core/ptf_pkg.sv */
// Constants and types for the test, timestamp and fault register bank
package ptf_pkg;
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_COMPLIANCE_TEST_SELECT = 10'h027;
  localparam logic [9:0] IDX_PINSEL = 10'h03e;
  localparam logic [9:0] IDX_TSCFG = 10'h03f;
  localparam logic [9:0] IDX_FIBER = 10'h040;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 11;
  // Reset values
  localparam logic [15:0] RST_COMPLIANCE_TEST_SELECT = 16'h0000;
  localparam logic [15:0] RST_PINSEL = 16'h0000;
  localparam logic [15:0] RST_TSCFG = 16'hb4ff;
  localparam logic [15:0] RST_FIBER = 16'hc11d;
  // Writable bits; read-only reserved bits of pin select read zero
  localparam logic [15:0] WMASK_COMPLIANCE_TEST_SELECT = 16'hffff;
  localparam logic [15:0] WMASK_PINSEL = 16'h0077;
  localparam logic [15:0] WMASK_TSCFG = 16'hffff;
  localparam logic [15:0] WMASK_FIBER = 16'hffff;
  // Compliance test fields
  localparam int CT_EN_BIT = 4;
  localparam int CT_CFG_MSB = 3;
  localparam int CT_CFG_LSB = 0;
  // Pin select fields
  localparam int PS_TX_MSB = 6;
  localparam int PS_TX_LSB = 4;
  localparam int PS_RX_MSB = 2;
  localparam int PS_RX_LSB = 0;
  // Timestamp configuration fields
  localparam int TC_TXT_MSB = 15;
  localparam int TC_TXT_LSB = 13;
  localparam int TC_RXT_MSB = 12;
  localparam int TC_RXT_LSB = 10;
  localparam int TC_ERR_MSB = 9;
  localparam int TC_ERR_LSB = 8;
  localparam int TC_TMR_MSB = 7;
  localparam int TC_TMR_LSB = 4;
  // Fiber fault bits
  localparam int FF_FORCE_BIT = 13;
  localparam int FF_GEN_DIS_BIT = 6;
  localparam int FF_DET_DIS_BIT = 5;
  // Timestamp indication step size
  localparam int TS_STEP_NS = 8;
  // 10 Mb/s pattern codes
  localparam logic [3:0] PAT_LINK_PULSE = 4'h0;
  localparam logic [3:0] PAT_ONE_PULSE = 4'h1;
  localparam logic [3:0] PAT_ZERO_PULSE = 4'h2;
  localparam logic [3:0] PAT_REP_ONES = 4'h3;
  localparam logic [3:0] PAT_REP_ZEROS = 4'h4;
  localparam logic [3:0] PAT_PREAMBLE = 4'h5;
  localparam logic [3:0] PAT_ONE_IDLE = 4'h6;
  localparam logic [3:0] PAT_ZERO_IDLE = 4'h7;
  localparam logic [3:0] PAT_SEQ_1001 = 4'h8;
  localparam logic [3:0] PAT_RANDOM = 4'h9;
  localparam logic [3:0] PAT_IDLE_00 = 4'ha;
  localparam logic [3:0] PAT_IDLE_01 = 4'hb;
  localparam logic [3:0] PAT_IDLE_11 = 4'hc;
  // 100 Mb/s code range, zeros after each one
  localparam logic [4:0] CODE100_MIN = 5'h01;
  localparam logic [4:0] CODE100_MAX = 5'h07;
  // Start-of-frame pin select codes
  localparam logic [2:0] SFD_LED0 = 3'h3;
  localparam logic [2:0] SFD_CRS = 3'h4;
  localparam logic [2:0] SFD_COL = 3'h5;
  localparam logic [2:0] SFD_INTPD = 3'h6;
  localparam logic [2:0] SFD_NONE = 3'h7;
  localparam int NUM_PINS = 4;
  localparam int PIN_LED0 = 0;
  localparam int PIN_CRS = 1;
  localparam int PIN_COL = 2;
  localparam int PIN_INTPD = 3;
  localparam logic [3:0][2:0] SFD_PIN_CODE = {SFD_INTPD, SFD_COL, SFD_CRS,
                                              SFD_LED0};
  // Transmit-error input select codes
  localparam logic [1:0] TXE_NONE = 2'h0;
  localparam logic [1:0] TXE_INTPD = 2'h2;
  localparam logic [1:0] TXE_COL = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Write channel states
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } ptf_wr_state_t;
endpackage

/* core/ptf_regs.sv */
// Test pattern, timestamp routing and fiber fault register bank
//
// Function
// - Enable bits start 10 and 100 test modes
// - Field codes 0000-0100 pick basic 10 patterns
// - Code 0101 sends alternating preamble pattern
// - Codes 0110-0111 single bit, 1010-1100 idles
// - 1000 sends 1001 sequence, 1001 random
// - Five-bit code gives zeros after each one
// - Transmit frame pulse routed by bits 6:4
// - Receive frame pulse routed by bits 2:0
// - Transmit timestamp timing field, 8 ns steps
// - Receive timestamp timing field, 8 ns steps
// - Bits 9:8 choose transmit error input pin
// - Bits 7:4 hold descrambler unlock timer
// - Bit 13 forces 100 Mb/s link up
// - Bit 6 stops far-end-fault generation
// - Bit 5 ignores received far-end-fault
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ptf_regs (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // AXI4-Lite write address and data
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [ptf_pkg::ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [ptf_pkg::DATA_W-1:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  // AXI4-Lite write response
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  // AXI4-Lite read
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [ptf_pkg::ADDR_W-1:0] I_AXI_ARADDR,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [ptf_pkg::DATA_W-1:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  // Extended test register inputs
  input wire logic I_EXT_TEST100_EN,
  input wire logic I_EXT_CODE_BIT5,
  // Test pattern controls
  output logic O_TEST10_EN,
  output logic O_TEST10_VALID,
  output logic [3:0] O_TEST10_PATTERN,
  output logic O_TEST100_ACTIVE,
  output logic O_TEST100_LOAD,
  output logic [2:0] O_TEST100_ZEROS,
  // Start-of-frame pulses and pin drive
  input wire logic I_TX_SFD,
  input wire logic I_RX_SFD,
  output logic [ptf_pkg::NUM_PINS-1:0] O_SFD_PIN,
  output logic [ptf_pkg::NUM_PINS-1:0] O_SFD_PIN_EN,
  // Timestamp and link timer settings
  output logic [2:0] O_TX_TS_STEPS,
  output logic [2:0] O_RX_TS_STEPS,
  output logic [3:0] O_UNLOCK_TIMER,
  // Transmit error inputs
  input wire logic I_INTPD_PIN,
  input wire logic I_COL_PIN,
  output logic O_TX_ERR,
  // Far-end fault and forced link
  input wire logic I_FEF_GEN_REQ,
  input wire logic I_FEF_RX,
  output logic O_FEF_GEN,
  output logic O_FEF_DETECTED,
  output logic O_FORCE_100_LINK
);
  import ptf_pkg::*;

  typedef struct packed {
    ptf_wr_state_t wr_state;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [REG_W-1:0] wdata;
    logic [1:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic [REG_W-1:0] compliance_test_select;
    logic [REG_W-1:0] pinsel;
    logic [REG_W-1:0] tscfg;
    logic [REG_W-1:0] fiber;
    logic en100_d;
    logic [4:0] code100;
    logic load100;
    logic tx_err;
    logic fef_gen;
    logic fef_det;
  } ptf_state_t;

  ptf_state_t st_ff;
  ptf_state_t nxt_st;
  logic aw_hs;
  logic w_hs;
  logic wr_commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0] wr_data;
  logic [1:0] wr_strb;
  logic [16:0] rd_word;
  logic code_ok;

  // Byte-lane merge of a write into one register
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old,
    input logic [REG_W-1:0] data,
    input logic [1:0] strb,
    input logic [REG_W-1:0] wmask
  );
    logic [REG_W-1:0] bm;
    bm = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~bm) | (data & bm);
  endfunction

  // Read decode, top bit flags a mapped address
  function automatic logic [16:0] rd_decode(
    input logic [ADDR_W-1:0] addr,
    input ptf_state_t s
  );
    logic [9:0] idx;
    idx = addr[IDX_MSB:IDX_LSB];
    case (idx)
      IDX_COMPLIANCE_TEST_SELECT: rd_decode = {1'b1, s.compliance_test_select};
      IDX_PINSEL: rd_decode = {1'b1, s.pinsel & WMASK_PINSEL};
      IDX_TSCFG: rd_decode = {1'b1, s.tscfg};
      IDX_FIBER: rd_decode = {1'b1, s.fiber};
      default: rd_decode = {1'b0, 16'h0000};
    endcase
  endfunction

  // Handshakes; address and data accepted in either order
  assign O_AXI_AWREADY = (st_ff.wr_state == WR_COLLECT) && !st_ff.aw_got;
  assign O_AXI_WREADY = (st_ff.wr_state == WR_COLLECT) && !st_ff.w_got;
  assign O_AXI_ARREADY = !st_ff.rvalid;
  assign aw_hs = I_AXI_AWVALID && O_AXI_AWREADY;
  assign w_hs = I_AXI_WVALID && O_AXI_WREADY;
  assign wr_commit = (st_ff.wr_state == WR_COLLECT) &&
                     (st_ff.aw_got || aw_hs) && (st_ff.w_got || w_hs);
  assign wr_addr = st_ff.aw_got ? st_ff.awaddr : I_AXI_AWADDR;
  assign wr_data = st_ff.w_got ? st_ff.wdata : I_AXI_WDATA[REG_W-1:0];
  assign wr_strb = st_ff.w_got ? st_ff.wstrb : I_AXI_WSTRB[1:0];
  assign rd_word = rd_decode(I_AXI_ARADDR, st_ff);
  // Valid 100 Mb/s codes are one to seven zeros
  assign code_ok = (st_ff.code100 >= CODE100_MIN) &&
                   (st_ff.code100 <= CODE100_MAX);

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.load100 = 1'b0;
    // Write channel
    case (st_ff.wr_state)
      WR_COLLECT: begin
        if (aw_hs) begin
          nxt_st.aw_got = 1'b1;
          nxt_st.awaddr = I_AXI_AWADDR;
        end
        if (w_hs) begin
          nxt_st.w_got = 1'b1;
          nxt_st.wdata = I_AXI_WDATA[REG_W-1:0];
          nxt_st.wstrb = I_AXI_WSTRB[1:0];
        end
        if (wr_commit) begin
          nxt_st.wr_state = WR_RESP;
          nxt_st.aw_got = 1'b0;
          nxt_st.w_got = 1'b0;
          nxt_st.bresp = RESP_OKAY;
          case (wr_addr[IDX_MSB:IDX_LSB])
            IDX_COMPLIANCE_TEST_SELECT: begin
              nxt_st.compliance_test_select = merge(st_ff.compliance_test_select, wr_data, wr_strb,
                                   WMASK_COMPLIANCE_TEST_SELECT);
            end
            IDX_PINSEL: begin
              nxt_st.pinsel = merge(st_ff.pinsel, wr_data, wr_strb,
                                    WMASK_PINSEL);
            end
            IDX_TSCFG: begin
              nxt_st.tscfg = merge(st_ff.tscfg, wr_data, wr_strb,
                                   WMASK_TSCFG);
            end
            IDX_FIBER: begin
              nxt_st.fiber = merge(st_ff.fiber, wr_data, wr_strb,
                                   WMASK_FIBER);
            end
            default: begin
              nxt_st.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      WR_RESP: begin
        if (I_AXI_BREADY) begin
          nxt_st.wr_state = WR_COLLECT;
        end
      end
      default: begin
        nxt_st.wr_state = WR_COLLECT;
      end
    endcase
    // Read channel, one outstanding read
    if (st_ff.rvalid) begin
      if (I_AXI_RREADY) begin
        nxt_st.rvalid = 1'b0;
      end
    end else if (I_AXI_ARVALID) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_word[REG_W-1:0];
      nxt_st.rresp = rd_word[16] ? RESP_OKAY : RESP_SLVERR;
    end
    // Pattern code captured only on a fresh 100 Mb/s enable
    nxt_st.en100_d = I_EXT_TEST100_EN;
    if (I_EXT_TEST100_EN && !st_ff.en100_d) begin
      nxt_st.code100 = {I_EXT_CODE_BIT5,
                        st_ff.compliance_test_select[CT_CFG_MSB:CT_CFG_LSB]};
      nxt_st.load100 = 1'b1;
    end
    // Transmit error source select
    case (st_ff.tscfg[TC_ERR_MSB:TC_ERR_LSB])
      TXE_INTPD: nxt_st.tx_err = I_INTPD_PIN;
      TXE_COL: nxt_st.tx_err = I_COL_PIN;
      default: nxt_st.tx_err = 1'b0;
    endcase
    // Far-end fault gating
    nxt_st.fef_gen = I_FEF_GEN_REQ && !st_ff.fiber[FF_GEN_DIS_BIT];
    nxt_st.fef_det = I_FEF_RX && !st_ff.fiber[FF_DET_DIS_BIT];
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_ff <= '0;
      st_ff.compliance_test_select <= RST_COMPLIANCE_TEST_SELECT;
      st_ff.pinsel <= RST_PINSEL;
      st_ff.tscfg <= RST_TSCFG;
      st_ff.fiber <= RST_FIBER;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pin routing of frame pulses
  ptf_sfd_route u_route (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_sel_tx(st_ff.pinsel[PS_TX_MSB:PS_TX_LSB]),
    .i_sel_rx(st_ff.pinsel[PS_RX_MSB:PS_RX_LSB]),
    .i_tx_sfd(I_TX_SFD),
    .i_rx_sfd(I_RX_SFD),
    .o_pin(O_SFD_PIN),
    .o_pin_en(O_SFD_PIN_EN)
  );

  // Bus outputs
  assign O_AXI_BVALID = (st_ff.wr_state == WR_RESP);
  assign O_AXI_BRESP = st_ff.bresp;
  assign O_AXI_RVALID = st_ff.rvalid;
  assign O_AXI_RDATA = {{(DATA_W-REG_W){1'b0}}, st_ff.rdata};
  assign O_AXI_RRESP = st_ff.rresp;

  // 10 Mb/s pattern: link pulse, pulses, preamble, 1001, random, idles
  assign O_TEST10_EN = st_ff.compliance_test_select[CT_EN_BIT];
  assign O_TEST10_PATTERN = st_ff.compliance_test_select[CT_CFG_MSB:CT_CFG_LSB];
  assign O_TEST10_VALID = O_TEST10_EN &&
                          (O_TEST10_PATTERN <= PAT_IDLE_11);
  // 100 Mb/s pattern: zero count from the loaded code
  assign O_TEST100_ACTIVE = I_EXT_TEST100_EN && code_ok;
  assign O_TEST100_ZEROS = O_TEST100_ACTIVE ? st_ff.code100[2:0] :
                           3'h0;
  assign O_TEST100_LOAD = st_ff.load100;
  // Settings passed to the timing and link logic
  assign O_TX_TS_STEPS = st_ff.tscfg[TC_TXT_MSB:TC_TXT_LSB];
  assign O_RX_TS_STEPS = st_ff.tscfg[TC_RXT_MSB:TC_RXT_LSB];
  assign O_UNLOCK_TIMER = st_ff.tscfg[TC_TMR_MSB:TC_TMR_LSB];
  assign O_TX_ERR = st_ff.tx_err;
  assign O_FEF_GEN = st_ff.fef_gen;
  assign O_FEF_DETECTED = st_ff.fef_det;
  assign O_FORCE_100_LINK = st_ff.fiber[FF_FORCE_BIT];

  // Checks on the documented behaviour
  default clocking cb_chk @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  a_test10_steady: assert property (
    $changed({O_TEST10_EN, O_TEST10_PATTERN}) |-> $past(wr_commit))
    else $error("10M pattern changed without a write");
  a_load_code: assert property (
    $rose(I_EXT_TEST100_EN) |=> O_TEST100_LOAD && st_ff.code100 ==
      {$past(I_EXT_CODE_BIT5), $past(st_ff.compliance_test_select[CT_CFG_MSB:CT_CFG_LSB])})
    else $error("100M code not loaded on enable");
  a_code_held: assert property (
    (I_EXT_TEST100_EN && st_ff.en100_d) |=> $stable(st_ff.code100))
    else $error("100M code changed while enabled");
  a_zero_count: assert property (
    O_TEST100_ZEROS != 3'h0 |-> O_TEST100_ACTIVE &&
      st_ff.code100[4:3] == 2'b00)
    else $error("zero count without valid code");
  a_sfd_led0: assert property (
    (st_ff.pinsel[PS_RX_MSB:PS_RX_LSB] == SFD_LED0 && I_RX_SFD)
      |=> O_SFD_PIN[PIN_LED0] && O_SFD_PIN_EN[PIN_LED0])
    else $error("rx frame pulse missing on led pin");
  a_sfd_none: assert property (
    (st_ff.pinsel[PS_TX_MSB:PS_TX_LSB] == SFD_NONE &&
     st_ff.pinsel[PS_RX_MSB:PS_RX_LSB] == SFD_NONE) |=> O_SFD_PIN_EN == '0)
    else $error("pin driven with no output selected");
  a_tx_err_col: assert property (
    st_ff.tscfg[TC_ERR_MSB:TC_ERR_LSB] == TXE_COL |=>
      O_TX_ERR == $past(I_COL_PIN))
    else $error("tx error not taken from col pin");
  a_tx_err_none: assert property (
    st_ff.tscfg[TC_ERR_MSB:TC_ERR_LSB] == TXE_NONE |=> !O_TX_ERR)
    else $error("tx error with no input selected");
  a_fef_gen_off: assert property (
    st_ff.fiber[FF_GEN_DIS_BIT] |=> !O_FEF_GEN)
    else $error("far-end fault generated while disabled");
  a_fef_det_off: assert property (
    st_ff.fiber[FF_DET_DIS_BIT] |=> !O_FEF_DETECTED)
    else $error("far-end fault detected while disabled");
  a_ts_steady: assert property (
    $changed(st_ff.tscfg) |-> $past(wr_commit))
    else $error("timing settings changed without a write");
  a_force_link: assert property (
    $rose(O_FORCE_100_LINK) |-> $past(wr_commit))
    else $error("forced link without a write");
endmodule

/* core/ptf_sfd_route.sv */
// Routes transmit and receive start-of-frame pulses onto output pins
`timescale 1ns/1ps
module ptf_sfd_route (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin selects
  input wire logic [2:0] i_sel_tx,
  input wire logic [2:0] i_sel_rx,
  // Start-of-frame pulses
  input wire logic i_tx_sfd,
  input wire logic i_rx_sfd,
  // Pin drive
  output logic [ptf_pkg::NUM_PINS-1:0] o_pin,
  output logic [ptf_pkg::NUM_PINS-1:0] o_pin_en
);
  import ptf_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0] pin;
    logic [NUM_PINS-1:0] pin_en;
  } ptf_route_t;

  ptf_route_t st_ff;
  ptf_route_t nxt_st;
  logic [NUM_PINS-1:0] hit_tx;
  logic [NUM_PINS-1:0] hit_rx;

  // Per-pin select match, both paths may share a pin
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    assign hit_tx[k] = (i_sel_tx == SFD_PIN_CODE[k]);
    assign hit_rx[k] = (i_sel_rx == SFD_PIN_CODE[k]);
  end

  // Next pin drive
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_en = hit_tx | hit_rx;
    nxt_st.pin = (hit_tx & {NUM_PINS{i_tx_sfd}}) |
                 (hit_rx & {NUM_PINS{i_rx_sfd}});
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pin = st_ff.pin;
  assign o_pin_en = st_ff.pin_en;
endmodule

/* tb/tb_phy_test_timestamp_fault_regs.sv */
// Self-checking bench for the test, timestamp and fault register bank
`timescale 1ns/1ps
module tb_phy_test_timestamp_fault_regs;
  import ptf_pkg::*;
  localparam logic [11:0] A_COMPLIANCE_TEST_SELECT = {IDX_COMPLIANCE_TEST_SELECT, 2'b00};
  localparam logic [11:0] A_PINSEL = {IDX_PINSEL, 2'b00};
  localparam logic [11:0] A_TSCFG = {IDX_TSCFG, 2'b00};
  localparam logic [11:0] A_FIBER = {IDX_FIBER, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic ext_en = 1'b0;
  logic ext_b5 = 1'b0;
  logic tx_sfd = 1'b0;
  logic rx_sfd = 1'b0;
  logic intpd = 1'b0;
  logic col = 1'b0;
  logic fef_req = 1'b0;
  logic fef_rx = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic t10_en, t10_valid, t100_act, t100_load, tx_err;
  logic fef_gen, fef_det, force_link;
  logic [3:0] t10_pat, sfd_pin, sfd_en, unlock_tmr;
  logic [2:0] t100_zeros, tx_steps, rx_steps;
  int mismatches = 0;
  int cmp_count = 0;

  // Free-running clock, 100 ns period
  always #50 clk = ~clk;

  ptf_regs dut_u (
    .I_CLK(clk), .I_RESETN(rst_n),
    .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_AWADDR(awaddr), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .O_AXI_BVALID(bvalid),
    .I_AXI_BREADY(bready), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .I_AXI_ARADDR(araddr), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
    .I_EXT_TEST100_EN(ext_en), .I_EXT_CODE_BIT5(ext_b5),
    .O_TEST10_EN(t10_en), .O_TEST10_VALID(t10_valid),
    .O_TEST10_PATTERN(t10_pat), .O_TEST100_ACTIVE(t100_act),
    .O_TEST100_LOAD(t100_load), .O_TEST100_ZEROS(t100_zeros),
    .I_TX_SFD(tx_sfd), .I_RX_SFD(rx_sfd), .O_SFD_PIN(sfd_pin),
    .O_SFD_PIN_EN(sfd_en), .O_TX_TS_STEPS(tx_steps),
    .O_RX_TS_STEPS(rx_steps), .O_UNLOCK_TIMER(unlock_tmr),
    .I_INTPD_PIN(intpd), .I_COL_PIN(col), .O_TX_ERR(tx_err),
    .I_FEF_GEN_REQ(fef_req), .I_FEF_RX(fef_rx), .O_FEF_GEN(fef_gen),
    .O_FEF_DETECTED(fef_det), .O_FORCE_100_LINK(force_link)
  );

  // Compare, count, report at once
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus write; address and data offered together, held until taken
  task automatic axi_wr(input logic [11:0] a, input logic [15:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= s;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // Bus read; address held until taken, data caught with rvalid
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Full-word write expecting OKAY, outputs settled on return
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'h3, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    @(negedge clk);
  endtask

  // Read expecting OKAY and a given value
  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk("rresp", 32'(RESP_OKAY), 32'(r));
  endtask

  // Reset values, reserved read-only bits, unmapped place
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("compliance_test_select", A_COMPLIANCE_TEST_SELECT, 32'h0);
    rd_chk("pinsel", A_PINSEL, 32'h0);
    rd_chk("tscfg", A_TSCFG, 32'hb4ff);
    rd_chk("fiber", A_FIBER, 32'hc11d);
    chk("tx steps", 32'h5, 32'(tx_steps));
    chk("rx steps", 32'h5, 32'(rx_steps));
    chk("unlock", 32'hf, 32'(unlock_tmr));
    chk("force", 32'h0, 32'(force_link));
    chk("sfd en", 32'h0, 32'(sfd_en));
    axi_rd(12'h200, d, r);
    chk("bad rd resp", 32'(RESP_SLVERR), 32'(r));
    chk("bad rd data", 32'h0, d);
    axi_wr(12'h204, 16'hffff, 4'h3, r);
    chk("bad wr resp", 32'(RESP_SLVERR), 32'(r));
    wr(A_PINSEL, 16'hffff);
    rd_chk("pinsel ro", A_PINSEL, 32'h0077);
  endtask

  // Every 10 Mb/s pattern code with the enable set, then cleared
  task automatic t_test10;
    for (int c = 0; c < 16; c++) begin
      wr(A_COMPLIANCE_TEST_SELECT, {11'h000, 1'b1, c[3:0]});
      chk("t10 en", 32'h1, 32'(t10_en));
      chk("t10 pat", 32'(c[3:0]), 32'(t10_pat));
      chk("t10 valid", 32'(c <= 12), 32'(t10_valid));
    end
    wr(A_COMPLIANCE_TEST_SELECT, 16'h0005);
    chk("t10 off", 32'h0, 32'(t10_en));
  endtask

  // 100 Mb/s codes loaded on the enable's rising edge only
  task automatic t_test100;
    logic [2:0] z;
    for (int c = 0; c < 9; c++) begin
      wr(A_COMPLIANCE_TEST_SELECT, {12'h000, (c == 8) ? 4'h3 : c[3:0]});
      z = (c >= 1 && c <= 7) ? c[2:0] : 3'h0;
      @(posedge clk);
      ext_en <= 1'b1;
      ext_b5 <= (c == 8);
      @(posedge clk);
      @(negedge clk);
      chk("t100 load", 32'h1, 32'(t100_load));
      chk("t100 zeros", 32'(z), 32'(t100_zeros));
      chk("t100 act", 32'(z != 3'h0), 32'(t100_act));
      wr(A_COMPLIANCE_TEST_SELECT, 16'h0002);
      chk("t100 hold", 32'(z), 32'(t100_zeros));
      chk("t100 1shot", 32'h0, 32'(t100_load));
      @(posedge clk);
      ext_en <= 1'b0;
    end
  endtask

  // Each selector code except 1 and 2 routes its pulse to one pin or none
  task automatic t_sfd;
    logic [3:0] e;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        if (c == 1 || c == 2) continue;
        if (p == 0) wr(A_PINSEL, {9'h000, c[2:0], 4'h7});
        else wr(A_PINSEL, {9'h000, 3'h7, 1'b0, c[2:0]});
        e = (c >= 3 && c <= 6) ? 4'h1 << (c - 3) : 4'h0;
        chk("sfd en", 32'(e), 32'(sfd_en));
        @(posedge clk);
        tx_sfd <= (p == 0);
        rx_sfd <= (p == 1);
        @(posedge clk);
        tx_sfd <= 1'b0;
        rx_sfd <= 1'b0;
        @(negedge clk);
        chk("sfd pin", 32'(e), 32'(sfd_pin));
      end
    end
  endtask

  // Error input choice, timing fields, byte strobe
  task automatic t_txerr;
    logic [1:0] r;
    logic ex;
    for (int s = 0; s < 4; s++) begin
      if (s == 1) continue;
      wr(A_TSCFG, {3'h2, 3'h6, s[1:0], 4'h9, 4'hf});
      chk("tx steps", 32'h2, 32'(tx_steps));
      chk("rx steps", 32'h6, 32'(rx_steps));
      chk("unlock", 32'h9, 32'(unlock_tmr));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        intpd <= v[0];
        col <= ~v[0];
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        ex = (s == 2) ? v[0] : ((s == 3) ? ~v[0] : 1'b0);
        chk("tx err", 32'(ex), 32'(tx_err));
      end
    end
    axi_wr(A_TSCFG, 16'h000f, 4'h1, r);
    chk("strb bresp", 32'(RESP_OKAY), 32'(r));
    rd_chk("tscfg strb", A_TSCFG, 32'h5b0f);
  endtask

  // Forced link and far-end-fault gating, every bit combination
  task automatic t_fiber;
    logic [15:0] d;
    @(posedge clk);
    fef_req <= 1'b1;
    fef_rx <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = 16'hc11d | {2'b00, i[0], 6'h00, i[1], i[2], 5'h00};
      wr(A_FIBER, d);
      @(posedge clk);
      @(negedge clk);
      chk("force", 32'(i[0]), 32'(force_link));
      chk("fef gen", 32'(!i[1]), 32'(fef_gen));
      chk("fef det", 32'(!i[2]), 32'(fef_det));
      rd_chk("fiber", A_FIBER, 32'(d));
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_test10;
    t_test100;
    t_sfd;
    t_txerr;
    t_fiber;
    test_done;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule
